// ---- include/fmgr_pkg.sv ----
// Constants and carrier types for the FIFO manager interrupt/data-port block.
// Assumes an 8-bit SFR bus from the CPU and a byte-wide serial host side.
// ============================================================================
// Functional notes
// - Interrupt is OR of enabled flags.
// - Flag write with bit7 high clears ones.
// - Data write while tx full sets collision.
// - Tx count at or below threshold sets flag.
// - Tx FIFO becoming full sets flag.
// - Rx count at or above threshold sets flag.
// - Byte into full rx FIFO lost, overrun.
// - Rx FIFO becoming full sets flag.
// - Enable bits gate matching flags.
// - Enable write bit7 flushes tx pointers.
// - Enable write bit6 flushes rx pointers.
// - Data port write pushes tx FIFO.
// - Data port read pops oldest rx byte.
// - Rx size register, at most 182.
// - Unused RAM goes to tx FIFO.
// - Block runs only while FIFO enable set.
// - Two threshold registers, reset zero.
package fmgr_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] FMGR_RX_THR_ADDR = 8'h9a;
  localparam logic [7:0] FMGR_TX_THR_ADDR = 8'h9b;
  localparam logic [7:0] FMGR_FLAGS_ADDR = 8'h9f;
  localparam logic [7:0] FMGR_EN_ADDR = 8'ha1;
  localparam logic [7:0] FMGR_DATA_ADDR = 8'ha2;
  localparam logic [7:0] FMGR_SIZE_ADDR = 8'ha3;
  localparam logic [7:0] FMGR_RESET_VAL = 8'h00;
  // ==========================================================================
  // Field positions
  localparam int FMGR_B_WCOL = 5;
  localparam int FMGR_B_TWLL = 4;
  localparam int FMGR_B_TFF = 3;
  localparam int FMGR_B_RWLH = 2;
  localparam int FMGR_B_ROVR = 1;
  localparam int FMGR_B_RFF = 0;
  localparam int FMGR_B_SETCLR = 7;
  localparam int FMGR_B_TX_POINTER_FLUSH = 7;
  localparam int FMGR_B_RX_POINTER_FLUSH = 6;
  localparam int FMGR_NFLAGS = 6;
  localparam logic [7:0] FMGR_RX_MAX = 8'hb6;
  localparam int FMGR_RAM_DEPTH = 256;
  // ==========================================================================
  // SFR access bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmgr_sfr_t;
endpackage : fmgr_pkg

// ---- rtl/fmgr_top.sv ----
// FIFO manager: six sticky flags, enables/flushes, data port, RAM split.
// Assumes the CPU SFR strobes and the host byte strobes are synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module fmgr_top
  import fmgr_pkg::*;
#(
  parameter int RAM_DEPTH = FMGR_RAM_DEPTH
)(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_fifo_en,
  // CPU SFR access
  input wire fmgr_sfr_t i_sfr,
  output logic [7:0] o_rdata,
  // Host side: received byte in, transmit byte out
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_tx_pop,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  // Interrupt request to CPU
  output logic o_irq
);
  localparam int AW = $clog2(RAM_DEPTH);

  // ==========================================================================
  // Shared RAM, rx region at bottom, tx region above it
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] rx_thr_ff, tx_thr_ff, size_ff, en_ff;
  logic [5:0] flags_ff, nxt_flags;
  logic [AW:0] rx_cnt_ff, tx_cnt_ff, rx_rd_ff, rx_wr_ff, tx_rd_ff, tx_wr_ff;
  logic [7:0] rdata_ff;
  logic irq_ff, txv_ff;
  logic [7:0] txb_ff;

  // Ring advance inside [base, base+cap)
  function automatic logic [AW:0] fmgr_adv(input logic [AW:0] p, input logic [AW:0] base,
                                           input logic [AW:0] cap);
    fmgr_adv = (p + 1'b1 >= base + cap) ? base : p + 1'b1;
  endfunction : fmgr_adv

  // Decode; block is frozen while FIFO enable low (run enable, clock not gated)
  wire run = i_ce & i_fifo_en;
  wire wr_flags = run & i_sfr.wr & (i_sfr.addr == FMGR_FLAGS_ADDR);
  wire wr_en = run & i_sfr.wr & (i_sfr.addr == FMGR_EN_ADDR);
  wire wr_data = run & i_sfr.wr & (i_sfr.addr == FMGR_DATA_ADDR);
  wire rd_data = run & i_sfr.rd & (i_sfr.addr == FMGR_DATA_ADDR);
  wire wr_size = run & i_sfr.wr & (i_sfr.addr == FMGR_SIZE_ADDR);
  wire wr_rthr = run & i_sfr.wr & (i_sfr.addr == FMGR_RX_THR_ADDR);
  wire wr_tthr = run & i_sfr.wr & (i_sfr.addr == FMGR_TX_THR_ADDR);
  // Sizes above the limit clamp, keeping tx at least the remainder
  wire [7:0] size_w = (i_sfr.wdata > FMGR_RX_MAX) ? FMGR_RX_MAX : i_sfr.wdata;
  wire [AW:0] rx_cap = (AW + 1)'(size_ff);
  wire [AW:0] tx_cap = (AW + 1)'(RAM_DEPTH) - rx_cap;
  wire tx_pointer_flush = wr_en & i_sfr.wdata[FMGR_B_TX_POINTER_FLUSH];
  wire rx_pointer_flush = wr_en & i_sfr.wdata[FMGR_B_RX_POINTER_FLUSH];
  wire tx_full = (tx_cnt_ff >= tx_cap);
  wire rx_full = (rx_cnt_ff >= rx_cap);
  wire rx_empty = (rx_cnt_ff == '0);
  wire tx_empty = (tx_cnt_ff == '0);
  wire push_tx = wr_data & ~tx_full & ~tx_pointer_flush;
  wire pop_rx = rd_data & ~rx_empty & ~rx_pointer_flush;
  wire push_rx = run & i_rx_valid & ~rx_full & ~rx_pointer_flush;
  wire pop_tx = run & i_tx_pop & txv_ff & ~tx_pointer_flush;
  // Next transmit head slot, cut to the RAM index width at the read
  wire [AW:0] tx_rd_nxt = fmgr_adv(tx_rd_ff, rx_cap, tx_cap);
  wire [AW:0] rx_nc = rx_cnt_ff + (AW + 1)'(push_rx) - (AW + 1)'(pop_rx);
  wire [AW:0] tx_nc = tx_cnt_ff + (AW + 1)'(push_tx) - (AW + 1)'(pop_tx);
  wire [5:0] events;
  assign events[FMGR_B_WCOL] = wr_data & tx_full;
  assign events[FMGR_B_TWLL] = run & (tx_cnt_ff <= (AW + 1)'(tx_thr_ff));
  assign events[FMGR_B_TFF] = run & tx_full;
  assign events[FMGR_B_RWLH] = run & (rx_cnt_ff >= (AW + 1)'(rx_thr_ff));
  assign events[FMGR_B_ROVR] = run & i_rx_valid & rx_full;
  assign events[FMGR_B_RFF] = run & rx_full;
  // Write clear/set first; hardware events win over a clear
  wire [5:0] wbits = i_sfr.wdata[5:0];
  wire [5:0] sw_flags = !wr_flags ? flags_ff :
    i_sfr.wdata[FMGR_B_SETCLR] ? (flags_ff & ~wbits) : (flags_ff | wbits);
  assign nxt_flags = sw_flags | events;
  wire nxt_irq = |(nxt_flags & en_ff[5:0]);

  // Readback mux; flag bit7 and bit6 read zero
  logic [7:0] rmux;
  always_comb
  begin
    unique case (i_sfr.addr)
      FMGR_FLAGS_ADDR: rmux = {2'b00, flags_ff};
      FMGR_EN_ADDR: rmux = {2'b00, en_ff[5:0]};
      FMGR_DATA_ADDR: rmux = rx_empty ? 8'h00 : ram[rx_rd_ff[AW-1:0]];
      FMGR_SIZE_ADDR: rmux = size_ff;
      FMGR_RX_THR_ADDR: rmux = rx_thr_ff;
      FMGR_TX_THR_ADDR: rmux = tx_thr_ff;
      default: rmux = 8'h00;
    endcase
  end

  // Control registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_thr_ff <= FMGR_RESET_VAL;
      tx_thr_ff <= FMGR_RESET_VAL;
      size_ff <= FMGR_RESET_VAL;
      en_ff <= FMGR_RESET_VAL;
      flags_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else if (run)
    begin
      if (wr_rthr) rx_thr_ff <= i_sfr.wdata;
      if (wr_tthr) tx_thr_ff <= i_sfr.wdata;
      if (wr_size) size_ff <= size_w;
      if (wr_en) en_ff <= {2'b00, i_sfr.wdata[5:0]}; // flush bits self-clear
      flags_ff <= nxt_flags;
      irq_ff <= nxt_irq;
      if (i_sfr.rd) rdata_ff <= rmux;
    end
  end

  // Pointers and counts; tx pointers live above the rx region
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_rd_ff <= '0;
      rx_wr_ff <= '0;
      tx_rd_ff <= '0;
      tx_wr_ff <= '0;
      rx_cnt_ff <= '0;
      tx_cnt_ff <= '0;
    end
    else if (run)
    begin
      if (rx_pointer_flush || wr_size)
      begin
        rx_rd_ff <= '0;
        rx_wr_ff <= '0;
        rx_cnt_ff <= '0;
      end
      else
      begin
        if (push_rx) rx_wr_ff <= fmgr_adv(rx_wr_ff, '0, rx_cap);
        if (pop_rx) rx_rd_ff <= fmgr_adv(rx_rd_ff, '0, rx_cap);
        rx_cnt_ff <= rx_nc;
      end
      if (tx_pointer_flush || wr_size)
      begin
        tx_rd_ff <= wr_size ? (AW + 1)'(size_w) : rx_cap;
        tx_wr_ff <= wr_size ? (AW + 1)'(size_w) : rx_cap;
        tx_cnt_ff <= '0;
      end
      else
      begin
        if (push_tx) tx_wr_ff <= fmgr_adv(tx_wr_ff, rx_cap, tx_cap);
        if (pop_tx) tx_rd_ff <= fmgr_adv(tx_rd_ff, rx_cap, tx_cap);
        tx_cnt_ff <= tx_nc;
      end
    end
  end

  // RAM writes, no reset needed on storage
  always_ff @(posedge i_clk)
  begin
    if (run && push_rx) ram[rx_wr_ff[AW-1:0]] <= i_rx_byte;
    if (run && push_tx) ram[tx_wr_ff[AW-1:0]] <= i_sfr.wdata;
  end

  // Transmit head presented to the host, registered
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      txv_ff <= 1'b0;
      txb_ff <= 8'h00;
    end
    else if (run)
    begin
      txv_ff <= (tx_nc != '0) & ~tx_pointer_flush & ~wr_size;
      txb_ff <= pop_tx ? ram[tx_rd_nxt[AW-1:0]] :
        (tx_empty & push_tx) ? i_sfr.wdata : ram[tx_rd_ff[AW-1:0]];
    end
  end

  assign o_rdata = rdata_ff;
  assign o_irq = irq_ff;
  assign o_tx_valid = txv_ff;
  assign o_tx_byte = txb_ff;

  // ==========================================================================
  // Assertions
  a_irq_follows_flags: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $past(run) |-> (o_irq == |($past(nxt_flags) & $past(en_ff[5:0]))))
    else $error("irq not OR of enabled flags");
  a_flag_clear_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_flags && i_sfr.wdata[7] && ~events[0] && i_sfr.wdata[0] |=> !flags_ff[0])
    else $error("flag clear failed");
  a_flag_set_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_flags && !i_sfr.wdata[7] && i_sfr.wdata[5] |=> flags_ff[5])
    else $error("flag set failed");
  a_wcol_on_full: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_data && tx_full |=> flags_ff[FMGR_B_WCOL])
    else $error("write collision missed");
  a_overrun_drop: assert property (@(posedge i_clk) disable iff (!i_nrst)
    run && i_rx_valid && rx_full && !rx_pointer_flush && !wr_size && !pop_rx |=>
    flags_ff[FMGR_B_ROVR] && $stable(rx_cnt_ff))
    else $error("overrun not flagged");
  a_tx_flush_empty: assert property (@(posedge i_clk) disable iff (!i_nrst)
    tx_pointer_flush |=> tx_cnt_ff == '0 && !o_tx_valid)
    else $error("tx flush failed");
  a_rx_flush_empty: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rx_pointer_flush |=> rx_cnt_ff == '0)
    else $error("rx flush failed");
  a_size_limit: assert property (@(posedge i_clk) disable iff (!i_nrst)
    size_ff <= FMGR_RX_MAX)
    else $error("rx size over limit");
  a_gated_freeze: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_fifo_en |=> $stable(flags_ff) && $stable(tx_cnt_ff))
    else $error("state moved while disabled");
  // Clock enable low must freeze the same state as the FIFO enable
  a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_ce |=> $stable(flags_ff) && $stable(rx_cnt_ff) && $stable(tx_cnt_ff))
    else $error("state moved while clock enable low");
  // A lone push grows the transmit count by exactly one
  a_tx_push_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
    push_tx && !pop_tx && !wr_size |=> tx_cnt_ff == $past(tx_cnt_ff) + 1'b1)
    else $error("tx count did not grow on push");
  // A lone pop shrinks the receive count by exactly one
  a_rx_pop_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pop_rx && !push_rx && !wr_size |=> rx_cnt_ff == $past(rx_cnt_ff) - 1'b1)
    else $error("rx count did not shrink on pop");
  c_rx_overrun: cover property (@(posedge i_clk) disable iff (!i_nrst) events[FMGR_B_ROVR]);
  c_irq_raised: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_irq));
  c_rx_full: cover property (@(posedge i_clk) disable iff (!i_nrst) rx_full && i_rx_valid);
  c_tx_push_pop: cover property (@(posedge i_clk) disable iff (!i_nrst) push_tx ##[1:5] pop_tx);
endmodule : fmgr_top
`default_nettype wire

// ---- sim/fmgr_host_model.sv ----
// Far-side model: serial host logic feeding receive bytes, draining transmit.
// Assumes the testbench calls send() and sets pop_en hierarchically.
`timescale 1ns/1ps
`default_nettype none
module fmgr_host_model (
  // Clock
  input wire logic i_clk,
  // Transmit side of the device
  input wire logic i_tx_valid,
  output logic o_tx_pop,
  // Receive side of the device
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte
);
  // ==========================================================================
  // Drain with random stalls, never popping an empty queue
  logic pop_en;
  initial
  begin
    pop_en = 1'b0;
    o_tx_pop = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'ha5;
  end
  always @(negedge i_clk)
    o_tx_pop <= pop_en & i_tx_valid & 1'($urandom_range(1));
  // One received byte, then the line shows no stale copy
  task automatic send(input logic [7:0] b);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    o_rx_byte = b;
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_byte = ~b;
  endtask : send
endmodule : fmgr_host_model
`default_nettype wire

// ---- sim/fifo_manager_irq_data_port_tb.sv ----
// Testbench: SFR driver with expectation queues, output watchers, verdict.
// Assumes fmgr_pkg, fmgr_top and fmgr_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fifo_manager_irq_data_port_tb;
  import fmgr_pkg::*;
  localparam int DEPTH = 192;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic fifo_en = 1'b1;
  logic ce = 1'b1;
  fmgr_sfr_t sfr = '0;
  logic [7:0] rdata, tx_byte, rx_byte, b;
  logic irq, tx_valid, rx_valid, tx_pop;
  logic [1:0] rd_p = 2'b00;
  logic [7:0] q_rd[$], q_tx[$], sent[$];
  int err_total = 0;
  int n_tests = 0;
  // ==========================================================================
  // Clock, device and far side
  always #10 clk = ~clk;
  fmgr_top #(.RAM_DEPTH(DEPTH)) dut (.i_clk(clk), .i_nrst(nrst), .i_ce(ce),
    .i_fifo_en(fifo_en), .i_sfr(sfr), .o_rdata(rdata), .i_rx_valid(rx_valid),
    .i_rx_byte(rx_byte), .i_tx_pop(tx_pop), .o_tx_valid(tx_valid),
    .o_tx_byte(tx_byte), .o_irq(irq));
  fmgr_host_model host (.i_clk(clk), .i_tx_valid(tx_valid), .o_tx_pop(tx_pop),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));
  // ==========================================================================
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic sfr_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge clk);
    sfr = '0;
    @(negedge clk);
  endtask : sfr_op
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_op(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    q_rd.push_back(exp);
    sfr_op(1'b0, a, 8'h00);
  endtask : rd
  task automatic final_report();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Watchers: read answers two edges after the strobe, popped bytes in order
  always @(posedge clk)
    rd_p <= {rd_p[0], sfr.rd & fifo_en & ce};
  always @(negedge clk)
    if (rd_p[1])
      chk(rdata, q_rd.pop_front());
  always @(posedge clk)
    if (tx_valid && tx_pop)
      chk(tx_byte, q_tx.pop_front());
  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #1000000;
    err_total++;
    final_report();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h3a0df8fc));
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    rd(FMGR_RX_THR_ADDR, 8'h00);
    rd(FMGR_TX_THR_ADDR, 8'h00);
    rd(FMGR_EN_ADDR, 8'h00);
    rd(FMGR_SIZE_ADDR, 8'h00);
    rd(8'h9c, 8'h00);
    rd(FMGR_FLAGS_ADDR, 8'h15);
    wr(FMGR_RX_THR_ADDR, 8'h03);
    wr(FMGR_TX_THR_ADDR, 8'h02);
    wr(FMGR_SIZE_ADDR, 8'hc8);
    rd(FMGR_SIZE_ADDR, FMGR_RX_MAX);
    wr(FMGR_FLAGS_ADDR, 8'hff);
    rd(FMGR_FLAGS_ADDR, 8'h10);
    wr(FMGR_FLAGS_ADDR, 8'h22);
    rd(FMGR_FLAGS_ADDR, 8'h32);
    wr(FMGR_FLAGS_ADDR, 8'ha0);
    rd(FMGR_FLAGS_ADDR, 8'h12);
    fifo_en = 1'b0;
    wr(FMGR_FLAGS_ADDR, 8'h28);
    fifo_en = 1'b1;
    rd(FMGR_FLAGS_ADDR, 8'h12);
    ce = 1'b0;
    wr(FMGR_FLAGS_ADDR, 8'h28);
    ce = 1'b1;
    rd(FMGR_FLAGS_ADDR, 8'h12);
    wr(FMGR_EN_ADDR, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(FMGR_EN_ADDR, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wr(FMGR_FLAGS_ADDR, 8'h82);
    chk({7'h0, irq}, 8'h00);
    // Fill the leftover ten bytes with the host stalled
    repeat (9)
    begin
      b = 8'($urandom);
      q_tx.push_back(b);
      wr(FMGR_DATA_ADDR, b);
    end
    wr(FMGR_FLAGS_ADDR, 8'hbf);
    rd(FMGR_FLAGS_ADDR, 8'h00);
    b = 8'($urandom);
    q_tx.push_back(b);
    wr(FMGR_DATA_ADDR, b);
    rd(FMGR_FLAGS_ADDR, 8'h08);
    wr(FMGR_DATA_ADDR, 8'h5a);
    rd(FMGR_FLAGS_ADDR, 8'h28);
    wr(FMGR_EN_ADDR, 8'h20);
    chk({7'h0, irq}, 8'h01);
    host.pop_en = 1'b1;
    repeat (200) if (q_tx.size() != 0) @(negedge clk);
    chk(8'(q_tx.size()), 8'h00);
    host.pop_en = 1'b0;
    wr(FMGR_DATA_ADDR, 8'h11);
    wr(FMGR_DATA_ADDR, 8'h22);
    wr(FMGR_EN_ADDR, 8'h80);
    chk({7'h0, tx_valid}, 8'h00);
    // Receive side: four-byte FIFO, fifth byte lost
    wr(FMGR_SIZE_ADDR, 8'h04);
    wr(FMGR_FLAGS_ADDR, 8'hff);
    repeat (5)
    begin
      b = 8'($urandom);
      sent.push_back(b);
      host.send(b);
    end
    rd(FMGR_FLAGS_ADDR, 8'h17);
    for (int i = 0; i < 4; i++) rd(FMGR_DATA_ADDR, sent[i]);
    rd(FMGR_DATA_ADDR, 8'h00);
    host.send(8'h3c);
    host.send(8'hc3);
    wr(FMGR_EN_ADDR, 8'h40);
    rd(FMGR_DATA_ADDR, 8'h00);
    repeat (2) @(negedge clk);
    final_report();
  end
endmodule : fifo_manager_irq_data_port_tb
`default_nettype wire
